/* File: iod_pkg.sv */
/*
 * Shared definitions for the I/O register space decoder: address map, field
 * masks, reset values, command codes and the carrier structs.
 * Assumes a single 10 MHz clock and a synchronous active-high reset.
 */
`default_nettype none

package iod_pkg;

    // ==========================================================================
    // Address map (I/O addresses; data-space address is I/O address plus 0x20)
    // ==========================================================================
    localparam logic [5:0] IO_PIN_B       = 6'h03;
    localparam logic [5:0] IO_DDR_B       = 6'h04;
    localparam logic [5:0] IO_OUT_B       = 6'h05;
    localparam logic [5:0] IO_PIN_C       = 6'h06;
    localparam logic [5:0] IO_DDR_C       = 6'h07;
    localparam logic [5:0] IO_OUT_C       = 6'h08;
    localparam logic [5:0] IO_PIN_D       = 6'h09;
    localparam logic [5:0] IO_DDR_D       = 6'h0a;
    localparam logic [5:0] IO_OUT_D       = 6'h0b;
    localparam logic [5:0] IO_PIN_A       = 6'h0c;
    localparam logic [5:0] IO_DDR_A       = 6'h0d;
    localparam logic [5:0] IO_OUT_A       = 6'h0e;
    localparam logic [5:0] IO_PORT_CR     = 6'h12;
    localparam logic [5:0] IO_T0_FLAGS    = 6'h15;
    localparam logic [5:0] IO_T1_FLAGS    = 6'h16;
    localparam logic [5:0] IO_SCRATCH0    = 6'h1e;
    localparam logic [5:0] IO_NVM_CTRL    = 6'h1f;
    localparam logic [5:0] IO_NVM_DATA    = 6'h20;
    localparam logic [5:0] IO_NVM_ADDR    = 6'h21;
    localparam logic [5:0] IO_GEN_TIMER   = 6'h23;
    localparam logic [5:0] IO_T0_CTRL     = 6'h25;
    localparam logic [5:0] IO_T0_COUNT    = 6'h26;
    localparam logic [5:0] IO_T0_CMP_A    = 6'h27;
    localparam logic [5:0] IO_T0_CMP_B    = 6'h28;
    localparam logic [5:0] IO_SCRATCH1    = 6'h2a;

    localparam logic [7:0] BIT_ADDR_LAST  = 8'h1f;
    localparam logic [7:0] IO_ADDR_LAST   = 8'h3f;
    localparam logic [7:0] DATA_IO_OFFSET = 8'h20;
    localparam logic [7:0] DATA_IO_LAST   = 8'h5f;
    localparam logic [7:0] EXT_FIRST      = 8'h60;
    localparam logic [7:0] EXT_LAST       = 8'hff;
    localparam int         EXT_DEPTH      = 160;

    // ==========================================================================
    // Implemented bit masks and reset value
    // ==========================================================================
    localparam logic [7:0] MASK_FULL      = 8'hff;
    localparam logic [7:0] MASK_PORT_A    = 8'h0f;
    localparam logic [7:0] MASK_T0_FLAGS  = 8'h07;
    localparam logic [7:0] MASK_T1_FLAGS  = 8'h27;
    localparam logic [7:0] MASK_NVM_CTRL  = 8'h3f;
    localparam logic [7:0] MASK_GEN_TIMER = 8'h81;
    localparam logic [7:0] MASK_T0_CTRL   = 8'h0f;
    localparam logic [7:0] RESET_VALUE    = 8'h00;

    // ==========================================================================
    // Commands and carriers
    // ==========================================================================
    typedef enum logic [3:0] {
        CMD_NONE,
        CMD_IO_READ,
        CMD_IO_WRITE,
        CMD_MEMORY_FETCH,
        CMD_MEMORY_PUT,
        CMD_BIT_SET,
        CMD_BIT_CLEAR,
        CMD_SKIP_HIGH,
        CMD_SKIP_LOW
    } iod_cmd_t;

    typedef struct packed {
        iod_cmd_t   cmd;
        logic [7:0] addr;
        logic [2:0] bitSel;
        logic [7:0] wdata;
    } iod_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       skip;
        logic       error;
    } iod_resp_t;

    typedef struct packed {
        logic [7:0] port_a_pin_input;
        logic [7:0] port_b_pin_input;
        logic [7:0] port_c_pin_input;
        logic [7:0] port_d_pin_input;
    } iod_pins_t;

    typedef struct packed {
        logic [7:0] port_b_direction;
        logic [7:0] outB;
        logic [7:0] port_c_direction;
        logic [7:0] outC;
        logic [7:0] port_d_direction;
        logic [7:0] outD;
        logic [7:0] port_a_direction;
        logic [7:0] outA;
        logic [7:0] port_drive_pullup_control;
        logic [7:0] t0Flags;
        logic [7:0] t1Flags;
        logic [7:0] scratch0;
        logic [7:0] nvmCtrl;
        logic [7:0] nvmData;
        logic [7:0] nvmAddr;
        logic [7:0] genTimer;
        logic [7:0] t0Ctrl;
        logic [7:0] t0Count;
        logic [7:0] t0CmpA;
        logic [7:0] t0CmpB;
        logic [7:0] scratch1;
    } iod_ctl_t;

endpackage : iod_pkg

`default_nettype wire

/* File: iod_ext_mem.sv */
/*
 * Extended I/O register storage, one byte per location, single port.
 * Assumes the caller presents an index below the depth; read data is registered.
 */
`timescale 1ns/1ps
`default_nettype none

module iod_ext_mem (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       en,
    input  wire logic       we,
    input  wire logic [7:0] index,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata
);
    import iod_pkg::*;

    typedef struct packed {
        logic [EXT_DEPTH-1:0][7:0] mem;
        logic [7:0]                rd;
    } iod_mem_state_t;

    iod_mem_state_t st;
    iod_mem_state_t next_st;

    always_comb begin
        next_st = st;
        if (en) begin
            if (we) begin
                next_st.mem[index] = wdata;
            end
            next_st.rd = st.mem[index];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rd;

endmodule : iod_ext_mem

`default_nettype wire

/* File: iod_io_space.sv */
/*
 * Lower I/O register space: decodes I/O, data-space and single-bit operations
 * from the core, holds the peripheral registers and the extended space.
 * Assumes requests and pin inputs synchronous to clk; one request per cycle.
 */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Bit set and clear work only on I/O addresses 0x00 to 0x1F.
// - Skip-if-bit-high and skip-if-bit-low test any bit in that range.
// - Flag bits clear when written one; writing zero leaves them.
// - Bit set or clear touches only the addressed bit.
// - I/O read and write cover I/O addresses 0x00 to 0x3F.
// - Data-space access reaches the same registers at address plus 0x20.
// - Extended registers 0x60 to 0xFF only through data-space access.
module iod_io_space (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire iod_pkg::iod_req_t  req,
    input  wire iod_pkg::iod_pins_t pins,
    input  wire logic [7:0]       t0FlagSet,
    input  wire logic [7:0]       t1FlagSet,
    output iod_pkg::iod_resp_t    resp,
    output iod_pkg::iod_ctl_t     ctl
);
    import iod_pkg::*;

    // ==========================================================================
    // State
    // ==========================================================================
    // Stage one (p1) holds the answer of the request taken at the last edge, and the
    // answer register drives the port one edge later, so every answer comes two edges on.
    typedef struct packed {
        iod_ctl_t   ctl;
        logic       p1Valid;
        logic       p1Ext;
        logic [7:0] p1Data;
        logic       p1Skip;
        logic       p1Error;
        iod_resp_t  resp;
    } iod_state_t;

    iod_state_t st;
    iod_state_t next_st;

    // ==========================================================================
    // Implemented bits
    // ==========================================================================
    // Implemented bits of each location; reserved locations and positions stay zero.
    function automatic logic [7:0] implMask(input logic [5:0] a);
        logic [7:0] m;
        m = RESET_VALUE;
        case (a)
            IO_PIN_B:     m = MASK_FULL;
            IO_DDR_B:     m = MASK_FULL;
            IO_OUT_B:     m = MASK_FULL;
            IO_PIN_C:     m = MASK_FULL;
            IO_DDR_C:     m = MASK_FULL;
            IO_OUT_C:     m = MASK_FULL;
            IO_PIN_D:     m = MASK_FULL;
            IO_DDR_D:     m = MASK_FULL;
            IO_OUT_D:     m = MASK_FULL;
            IO_PIN_A:     m = MASK_PORT_A;
            IO_DDR_A:     m = MASK_PORT_A;
            IO_OUT_A:     m = MASK_PORT_A;
            IO_PORT_CR:   m = MASK_FULL;
            IO_T0_FLAGS:  m = MASK_T0_FLAGS;
            IO_T1_FLAGS:  m = MASK_T1_FLAGS;
            IO_SCRATCH0:  m = MASK_FULL;
            IO_NVM_CTRL:  m = MASK_NVM_CTRL;
            IO_NVM_DATA:  m = MASK_FULL;
            IO_NVM_ADDR:  m = MASK_FULL;
            IO_GEN_TIMER: m = MASK_GEN_TIMER;
            IO_T0_CTRL:   m = MASK_T0_CTRL;
            IO_T0_COUNT:  m = MASK_FULL;
            IO_T0_CMP_A:  m = MASK_FULL;
            IO_T0_CMP_B:  m = MASK_FULL;
            IO_SCRATCH1:  m = MASK_FULL;
            default:      m = RESET_VALUE;
        endcase
        return m;
    endfunction : implMask

    // ==========================================================================
    // Decode helpers
    // ==========================================================================
    // Pin registers read the live pin levels and ignore writes.
    function automatic logic [7:0] ioRead(input iod_ctl_t c, input iod_pins_t p, input logic [5:0] a);
        logic [7:0] v;
        v = RESET_VALUE;
        case (a)
            IO_PIN_B:     v = p.port_b_pin_input;
            IO_DDR_B:     v = c.port_b_direction;
            IO_OUT_B:     v = c.outB;
            IO_PIN_C:     v = p.port_c_pin_input;
            IO_DDR_C:     v = c.port_c_direction;
            IO_OUT_C:     v = c.outC;
            IO_PIN_D:     v = p.port_d_pin_input;
            IO_DDR_D:     v = c.port_d_direction;
            IO_OUT_D:     v = c.outD;
            IO_PIN_A:     v = p.port_a_pin_input & MASK_PORT_A;
            IO_DDR_A:     v = c.port_a_direction;
            IO_OUT_A:     v = c.outA;
            IO_PORT_CR:   v = c.port_drive_pullup_control;
            IO_T0_FLAGS:  v = c.t0Flags;
            IO_T1_FLAGS:  v = c.t1Flags;
            IO_SCRATCH0:  v = c.scratch0;
            IO_NVM_CTRL:  v = c.nvmCtrl;
            IO_NVM_DATA:  v = c.nvmData;
            IO_NVM_ADDR:  v = c.nvmAddr;
            IO_GEN_TIMER: v = c.genTimer;
            IO_T0_CTRL:   v = c.t0Ctrl;
            IO_T0_COUNT:  v = c.t0Count;
            IO_T0_CMP_A:  v = c.t0CmpA;
            IO_T0_CMP_B:  v = c.t0CmpB;
            IO_SCRATCH1:  v = c.scratch1;
            default:      v = RESET_VALUE;
        endcase
        return v & implMask(a);
    endfunction : ioRead

    function automatic logic isFlagReg(input logic [5:0] a);
        return (a == IO_T0_FLAGS) || (a == IO_T1_FLAGS);
    endfunction : isFlagReg

    // Bit test shared by both skip operations.
    function automatic logic bitTest(input logic [7:0] v, input logic [2:0] sel, input logic wantHigh);
        return wantHigh ? v[sel] : !v[sel];
    endfunction : bitTest

    function automatic iod_ctl_t ioWrite(input iod_ctl_t c, input logic [5:0] a, input logic [7:0] d);
        iod_ctl_t n;
        n = c;
        case (a)
            IO_DDR_B:     n.port_b_direction     = d;
            IO_OUT_B:     n.outB     = d;
            IO_DDR_C:     n.port_c_direction     = d;
            IO_OUT_C:     n.outC     = d;
            IO_DDR_D:     n.port_d_direction     = d;
            IO_OUT_D:     n.outD     = d;
            IO_DDR_A:     n.port_a_direction     = d & MASK_PORT_A;
            IO_OUT_A:     n.outA     = d & MASK_PORT_A;
            IO_PORT_CR:   n.port_drive_pullup_control   = d;
            IO_T0_FLAGS:  n.t0Flags  = c.t0Flags & ~(d & MASK_T0_FLAGS);
            IO_T1_FLAGS:  n.t1Flags  = c.t1Flags & ~(d & MASK_T1_FLAGS);
            IO_SCRATCH0:  n.scratch0 = d;
            IO_NVM_CTRL:  n.nvmCtrl  = d & MASK_NVM_CTRL;
            IO_NVM_DATA:  n.nvmData  = d;
            IO_NVM_ADDR:  n.nvmAddr  = d;
            IO_GEN_TIMER: n.genTimer = d & MASK_GEN_TIMER;
            IO_T0_CTRL:   n.t0Ctrl   = d & MASK_T0_CTRL;
            IO_T0_COUNT:  n.t0Count  = d;
            IO_T0_CMP_A:  n.t0CmpA   = d;
            IO_T0_CMP_B:  n.t0CmpB   = d;
            IO_SCRATCH1:  n.scratch1 = d;
            default:      n = c;
        endcase
        return n;
    endfunction : ioWrite

    // ==========================================================================
    // Request decode
    // ==========================================================================
    logic       ioHit;
    logic [5:0] ioAddr;
    logic       extHit;
    logic       reqError;
    logic       isRead;
    logic       isWrite;
    logic       isBitOp;
    logic [7:0] extIndex;
    logic [7:0] extRdata;

    always_comb begin
        ioHit    = 1'b0;
        ioAddr   = req.addr[5:0];
        extHit   = 1'b0;
        reqError = 1'b0;
        isRead   = 1'b0;
        isWrite  = 1'b0;
        isBitOp  = 1'b0;
        extIndex = 8'(req.addr - EXT_FIRST);
        case (req.cmd)
            // The dedicated I/O operations reach only the 64-location window; the
            // extended space answers to data-space access alone.
            CMD_IO_READ, CMD_IO_WRITE: begin
                ioHit    = (req.addr <= IO_ADDR_LAST);
                reqError = !ioHit;
                isRead   = (req.cmd == CMD_IO_READ);
                isWrite  = (req.cmd == CMD_IO_WRITE);
            end
            // Data-space addresses below the I/O window belong to the core's working
            // registers, which live outside this block, so they are refused.
            CMD_MEMORY_FETCH, CMD_MEMORY_PUT: begin
                isRead  = (req.cmd == CMD_MEMORY_FETCH);
                isWrite = (req.cmd == CMD_MEMORY_PUT);
                if (req.addr >= EXT_FIRST && req.addr <= EXT_LAST) begin
                    extHit = 1'b1;
                end else if (req.addr >= DATA_IO_OFFSET && req.addr <= DATA_IO_LAST) begin
                    ioHit  = 1'b1;
                    ioAddr = 6'(req.addr - DATA_IO_OFFSET);
                end else begin
                    reqError = 1'b1;
                end
            end
            // Bit operations and skips are limited to the bit-addressable bottom half.
            CMD_BIT_SET, CMD_BIT_CLEAR, CMD_SKIP_HIGH, CMD_SKIP_LOW: begin
                ioHit    = (req.addr <= BIT_ADDR_LAST);
                reqError = !ioHit;
                isBitOp  = 1'b1;
            end
            default: begin
                ioHit = 1'b0;
            end
        endcase
    end

    // ==========================================================================
    // Extended space storage
    // ==========================================================================
    // The extended space registers its read data, so its answer lines up with
    // stage one of the register pipeline without an extra flop here.
    iod_ext_mem u_ext_mem (
        .clk   (clk),
        .reset (reset),
        .en    (extHit),
        .we    (extHit && isWrite),
        .index (extIndex),
        .wdata (req.wdata),
        .rdata (extRdata)
    );

    // ==========================================================================
    // Register update and answer pipeline
    // ==========================================================================
    logic [7:0] curValue;
    logic [7:0] bitMask;
    logic [7:0] bitData;

    always_comb begin
        next_st  = st;
        curValue = ioRead(st.ctl, pins, ioAddr);
        bitMask  = 8'h01 << req.bitSel;
        bitData  = curValue;

        // Stored writes pass through the implemented-bit mask, so reserved
        // positions stay zero whatever the core sends.
        if (ioHit && isWrite) begin
            next_st.ctl = ioWrite(st.ctl, ioAddr, req.wdata & implMask(ioAddr));
        end

        // On a flag register only the addressed bit is written; a read-modify-write
        // there would write back ones and clear other pending flags.
        if (ioHit && (req.cmd == CMD_BIT_SET || req.cmd == CMD_BIT_CLEAR)) begin
            if (isFlagReg(ioAddr)) begin
                bitData = (req.cmd == CMD_BIT_SET) ? bitMask : RESET_VALUE;
            end else if (req.cmd == CMD_BIT_SET) begin
                bitData = curValue | bitMask;
            end else begin
                bitData = curValue & ~bitMask;
            end
            next_st.ctl = ioWrite(st.ctl, ioAddr, bitData);
        end

        // A flag event in the cycle of its clear still sets the flag.
        next_st.ctl.t0Flags = next_st.ctl.t0Flags | (t0FlagSet & MASK_T0_FLAGS);
        next_st.ctl.t1Flags = next_st.ctl.t1Flags | (t1FlagSet & MASK_T1_FLAGS);

        next_st.p1Valid = (req.cmd != CMD_NONE);
        next_st.p1Ext   = extHit && isRead;
        // Writes answer with zero data; reads and bit operations return the value
        // seen at the taking edge.
        next_st.p1Data  = (ioHit && (isRead || isBitOp)) ? curValue : RESET_VALUE;
        next_st.p1Error = reqError;
        next_st.p1Skip  = 1'b0;
        if (ioHit && req.cmd == CMD_SKIP_HIGH) begin
            next_st.p1Skip = bitTest(curValue, req.bitSel, 1'b1);
        end else if (ioHit && req.cmd == CMD_SKIP_LOW) begin
            next_st.p1Skip = bitTest(curValue, req.bitSel, 1'b0);
        end

        next_st.resp.valid = st.p1Valid;
        next_st.resp.data  = st.p1Ext ? extRdata : st.p1Data;
        next_st.resp.skip  = st.p1Skip;
        next_st.resp.error = st.p1Error;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign resp = st.resp;
    assign ctl  = st.ctl;

endmodule : iod_io_space

`default_nettype wire

/* File: iod_io_space_sva.sv */
/*
 * Checker for the I/O register space decoder, bound to its top module.
 * Assumes one clock domain and the synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module iod_io_space_chk (
    input wire logic               clk,
    input wire logic               reset,
    input wire iod_pkg::iod_req_t  req,
    input wire iod_pkg::iod_pins_t pins,
    input wire logic [7:0]         t0FlagSet,
    input wire logic [7:0]         t1FlagSet,
    input wire iod_pkg::iod_resp_t resp,
    input wire iod_pkg::iod_ctl_t  ctl
);
    import iod_pkg::*;
    logic [1:0] skipPipe;
    always_ff @(posedge clk) begin
        skipPipe <= {skipPipe[0], ctl.scratch0[req.bitSel]};
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    AST_LATENCY: assert property (
        req.cmd != CMD_NONE |-> ##2 resp.valid) else $error("answer not two cycles after request");
    AST_NO_SPURIOUS: assert property (
        resp.valid |-> $past(req.cmd, 2) != CMD_NONE) else $error("answer without request");
    AST_IO_REFUSE: assert property (
        req.cmd inside {CMD_IO_READ, CMD_IO_WRITE} && req.addr > IO_ADDR_LAST |-> ##2 resp.error)
        else $error("io access above range not refused");
    AST_IO_ACCEPT: assert property (
        req.cmd inside {CMD_IO_READ, CMD_IO_WRITE} && req.addr <= IO_ADDR_LAST |-> ##2 !resp.error)
        else $error("io access in range refused");
    AST_MEM_REFUSE: assert property (
        req.cmd inside {CMD_MEMORY_FETCH, CMD_MEMORY_PUT} && req.addr < DATA_IO_OFFSET |-> ##2 resp.error)
        else $error("data access below offset not refused");
    AST_BIT_RANGE: assert property (
        req.cmd inside {CMD_BIT_SET, CMD_BIT_CLEAR, CMD_SKIP_HIGH, CMD_SKIP_LOW}
        && req.addr > BIT_ADDR_LAST |-> ##2 resp.error)
        else $error("bit operation above range not refused");
    AST_BIT_ONLY: assert property (
        req.cmd == CMD_BIT_SET && req.addr == {2'b00, IO_SCRATCH0}
        |=> ctl.scratch0 == ($past(ctl.scratch0) | (8'h01 << $past(req.bitSel))))
        else $error("bit set touched other bits");
    AST_W1C: assert property (
        req.cmd == CMD_IO_WRITE && req.addr == {2'b00, IO_T0_FLAGS} && t0FlagSet == 8'h00
        |=> ctl.t0Flags == ($past(ctl.t0Flags) & ~$past(req.wdata))) else $error("flag write wrong");
    AST_SKIP: assert property (
        req.cmd == CMD_SKIP_HIGH && req.addr == {2'b00, IO_SCRATCH0} |-> ##2 resp.skip == skipPipe[1])
        else $error("skip answer wrong");
    AST_PIN_RO: assert property (
        req.cmd == CMD_IO_WRITE && req.addr == {2'b00, IO_PIN_B} && t0FlagSet == 8'h00 && t1FlagSet == 8'h00
        |=> $stable(ctl)) else $error("pin register write changed state");
    COV_FLAG_BIT: cover property (req.cmd == CMD_BIT_SET && req.addr == {2'b00, IO_T0_FLAGS});
    COV_SKIP_LOW: cover property (req.cmd == CMD_SKIP_LOW);
    COV_EXT_PUT: cover property (req.cmd == CMD_MEMORY_PUT && req.addr >= EXT_FIRST);
endmodule : iod_io_space_chk

bind iod_io_space iod_io_space_chk chk_u (.clk(clk), .reset(reset), .req(req), .pins(pins),
    .t0FlagSet(t0FlagSet), .t1FlagSet(t1FlagSet), .resp(resp), .ctl(ctl));

`default_nettype wire

/* File: iod_core_model.sv */
/*
 * Core-side model: issues one request at a time and collects its answer.
 * Assumes the block answers within four cycles of taking a request.
 */
`timescale 1ns/1ps
`default_nettype none

module iod_core_model (
    input  wire logic               clk,
    output iod_pkg::iod_req_t       req,
    input  wire iod_pkg::iod_resp_t resp
);
    import iod_pkg::*;
    initial req = '0;
    // Holds the request for one cycle, then shows inverted fields so stale values never pass.
    task automatic run(input iod_cmd_t c, input logic [7:0] a, input logic [2:0] b,
                       input logic [7:0] w, output iod_resp_t r);
        int n;
        @(negedge clk);
        req <= '{cmd: c, addr: a, bitSel: b, wdata: w};
        @(negedge clk);
        req <= '{cmd: CMD_NONE, addr: ~a, bitSel: ~b, wdata: ~w};
        for (n = 0; n < 4 && resp.valid !== 1'b1; n++) @(negedge clk);
        r = resp;
    endtask : run
endmodule : iod_core_model

`default_nettype wire

/* File: tb.sv */
/*
 * Self-checking bench for the I/O register space decoder.
 * Assumes the core model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    import iod_pkg::*;
    typedef struct packed {
        iod_cmd_t   cmd;
        logic [7:0] addr;
        logic [2:0] bitSel;
        logic [7:0] wdata;
        logic [7:0] expData;
        logic       expSkip;
        logic       expErr;
    } iod_row_t;
    logic      clk;
    logic      reset;
    iod_pins_t pins;
    logic [7:0] t0FlagSet;
    logic [7:0] t1FlagSet;
    iod_req_t  req;
    iod_resp_t resp;
    iod_ctl_t  ctl;
    int        nErrors = 0;
    int        checks = 0;
    iod_row_t rows [$] = '{
        '{CMD_IO_WRITE, 8'h05, 3'h0, 8'ha5, 8'h00, 1'b0, 1'b0},
        '{CMD_IO_READ, 8'h05, 3'h0, 8'h00, 8'ha5, 1'b0, 1'b0},
        '{CMD_MEMORY_FETCH, 8'h25, 3'h0, 8'h00, 8'ha5, 1'b0, 1'b0},
        '{CMD_MEMORY_PUT, 8'h45, 3'h0, 8'h0f, 8'h00, 1'b0, 1'b0},
        '{CMD_IO_READ, 8'h25, 3'h0, 8'h00, 8'h0f, 1'b0, 1'b0},
        '{CMD_IO_READ, 8'h0c, 3'h0, 8'h00, 8'h0f, 1'b0, 1'b0},
        '{CMD_IO_WRITE, 8'h03, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0},
        '{CMD_IO_READ, 8'h03, 3'h0, 8'h00, 8'h5a, 1'b0, 1'b0},
        '{CMD_IO_READ, 8'h3f, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0},
        '{CMD_IO_READ, 8'h40, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1},
        '{CMD_MEMORY_PUT, 8'h80, 3'h0, 8'h5a, 8'h00, 1'b0, 1'b0},
        '{CMD_MEMORY_FETCH, 8'h80, 3'h0, 8'h00, 8'h5a, 1'b0, 1'b0},
        '{CMD_MEMORY_FETCH, 8'h60, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0},
        '{CMD_IO_READ, 8'h80, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1},
        '{CMD_MEMORY_FETCH, 8'h1f, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1},
        '{CMD_MEMORY_FETCH, 8'h5f, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0},
        '{CMD_BIT_SET, 8'h1e, 3'h7, 8'h00, 8'h00, 1'b0, 1'b0},
        '{CMD_IO_READ, 8'h1e, 3'h0, 8'h00, 8'h80, 1'b0, 1'b0},
        '{CMD_SKIP_HIGH, 8'h1e, 3'h7, 8'h00, 8'h80, 1'b1, 1'b0},
        '{CMD_SKIP_LOW, 8'h1e, 3'h7, 8'h00, 8'h80, 1'b0, 1'b0},
        '{CMD_SKIP_LOW, 8'h1e, 3'h6, 8'h00, 8'h80, 1'b1, 1'b0},
        '{CMD_BIT_CLEAR, 8'h1e, 3'h7, 8'h00, 8'h80, 1'b0, 1'b0},
        '{CMD_SKIP_HIGH, 8'h3e, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1},
        '{CMD_MEMORY_FETCH, 8'h3e, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0},
        '{CMD_BIT_SET, 8'h20, 3'h0, 8'h00, 8'h00, 1'b0, 1'b1},
        '{CMD_IO_READ, 8'h20, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0},
        '{CMD_IO_WRITE, 8'h2a, 3'h0, 8'h3c, 8'h00, 1'b0, 1'b0},
        '{CMD_IO_READ, 8'h2a, 3'h0, 8'h00, 8'h3c, 1'b0, 1'b0},
        '{CMD_IO_READ, 8'h00, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0}
    };

    iod_io_space dut_u (.clk(clk), .reset(reset), .req(req), .pins(pins), .t0FlagSet(t0FlagSet),
                        .t1FlagSet(t1FlagSet), .resp(resp), .ctl(ctl));
    iod_core_model core_u (.clk(clk), .req(req), .resp(resp));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            nErrors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic op(input iod_cmd_t c, input logic [7:0] a, input logic [2:0] b, input logic [7:0] w,
                      input logic [10:0] exp);
        iod_resp_t r;
        core_u.run(c, a, b, w, r);
        chk({r.valid, r.data, r.skip, r.error}, exp, "answer");
    endtask : op

    task automatic summarize();
        if (nErrors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        #1_000_000;
        nErrors++;
        summarize();
    end

    initial begin
        reset = 1'b1;
        pins = '{port_a_pin_input: 8'hff, port_b_pin_input: 8'h5a, port_c_pin_input: 8'h00, port_d_pin_input: 8'h00};
        t0FlagSet = 8'h00;
        t1FlagSet = 8'h00;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chk({10'h000, ctl === '0}, 11'h001, "reset state");
        foreach (rows[i]) begin
            op(rows[i].cmd, rows[i].addr, rows[i].bitSel, rows[i].wdata,
               {1'b1, rows[i].expData, rows[i].expSkip, rows[i].expErr});
        end
        @(negedge clk);
        t0FlagSet = 8'hff;
        t1FlagSet = 8'hff;
        @(negedge clk);
        t0FlagSet = 8'h00;
        t1FlagSet = 8'h00;
        chk({3'h0, ctl.t0Flags}, 11'h007, "timer0 flags set");
        chk({3'h0, ctl.t1Flags}, 11'h027, "timer1 flags set");
        op(CMD_BIT_SET, 8'h15, 3'h1, 8'h00, 11'h41c);
        chk({3'h0, ctl.t0Flags}, 11'h005, "flag bit clear");
        op(CMD_IO_WRITE, 8'h15, 3'h0, 8'h00, 11'h400);
        op(CMD_BIT_CLEAR, 8'h15, 3'h0, 8'h00, 11'h414);
        chk({3'h0, ctl.t0Flags}, 11'h005, "zero write kept flags");
        fork
            op(CMD_IO_WRITE, 8'h15, 3'h0, 8'h01, 11'h400);
            begin
                @(negedge clk);
                t0FlagSet = 8'h01;
                @(negedge clk);
                t0FlagSet = 8'h00;
            end
        join
        chk({3'h0, ctl.t0Flags}, 11'h005, "flag event beats clear");
        op(CMD_IO_WRITE, 8'h16, 3'h0, 8'h20, 11'h400);
        chk({3'h0, ctl.t1Flags}, 11'h007, "timer1 flag clear");
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chk({10'h000, ctl === '0}, 11'h001, "second reset");
        op(CMD_IO_READ, 8'h05, 3'h0, 8'h00, 11'h400);
        summarize();
    end
endmodule : tb

`default_nettype wire
